// *** hw/opz_ctl.sv ***
// Controller end: drives link clock, CKE, ODT, commands; keeps ZQ rules
`timescale 1ns/1ps
module opz_ctl
    import opz_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic                  clk_en,
    opz_link_if.ctl                    link,
    input  wire logic                  req_valid,
    input  wire logic [2:0]            req_cmd,
    input  wire logic                  req_cke,
    input  wire logic                  req_odt,
    input  wire logic                  banks_precharged,
    input  wire logic                  peer_zq_busy,
    output logic                       req_ready,
    output logic                       zq_active,
    output logic                       rtt_uncertain
);
    import opz_pkg::*;

    localparam int unsigned OPZ_DIV = OPZ_TCK_NS / (2 * OPZ_REF_NS);

    // ==============================================
    // Link clock divider; outputs change on falling link edges
    logic [4:0]           div_ff;
    logic                 ck_ff, cke_ff, odt_ff;
    logic [2:0]           cmd_ff;
    logic [OPZ_CNT_W-1:0] quiet_ff, win_ff;
    logic                 last_zq_ff;
    wire  ck_fall_tick = ck_ff & (div_ff == 5'(OPZ_DIV - 1));
    // ZQ only with banks precharged, outside tXS/tRP and peer calibration
    wire  is_zq  = (req_cmd == OPZ_CMD_ZQCL) | (req_cmd == OPZ_CMD_ZQCS);
    wire  zq_ok  = banks_precharged & ~peer_zq_busy & cke_ff;
    wire  quiet  = (quiet_ff != '0);
    assign req_ready = ck_fall_tick & ~quiet & (~is_zq | zq_ok);
    wire  take   = req_valid & req_ready;
    wire [OPZ_CNT_W-1:0] zq_len = (req_cmd == OPZ_CMD_ZQCS) ? OPZ_CNT_W'(OPZ_TZQCS)
                                                            : OPZ_CNT_W'(OPZ_TZQINIT);
    wire [OPZ_CNT_W-1:0] hold_len = is_zq ? zq_len :
        (req_cmd == OPZ_CMD_SRX) ? OPZ_CNT_W'(OPZ_TXS) : OPZ_CNT_W'(OPZ_TRP);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff   <= 5'h0;
            ck_ff    <= 1'b0;
            cke_ff   <= 1'b0;
            odt_ff   <= 1'b0;
            cmd_ff   <= 3'h0;
            quiet_ff <= '0;
            win_ff   <= '0;
            last_zq_ff <= 1'b0;
        end else if (clk_en) begin
            div_ff <= (div_ff == 5'(OPZ_DIV - 1)) ? 5'h0 : div_ff + 5'h1;
            if (div_ff == 5'(OPZ_DIV - 1)) ck_ff <= ~ck_ff;
            if (ck_fall_tick) begin
                cmd_ff <= take ? req_cmd : 3'h0;
                if (take) begin
                    // CKE stays high and ODT low through calibration
                    cke_ff <= is_zq ? 1'b1 : req_cke;
                    odt_ff <= is_zq ? 1'b0 : req_odt;
                    quiet_ff <= hold_len;
                    last_zq_ff <= is_zq;
                end else if (quiet)
                    quiet_ff <= quiet_ff - 1'b1;
                // Entry/exit windows: tANPD plus tXPDLL plus tRFC, counted from the CKE change
                if (take && cke_ff != req_cke && !is_zq)
                    win_ff <= OPZ_CNT_W'(OPZ_TANPD + OPZ_TXPDLL + OPZ_TRFC);
                else if (win_ff != '0)
                    win_ff <= win_ff - 1'b1;
            end
        end
    end

    // Quiet time that follows a calibration command, not tRP or tXS
    assign zq_active      = quiet & last_zq_ff;
    assign rtt_uncertain  = (win_ff != '0);
    assign link.ck        = ck_ff;
    assign link.cke       = cke_ff;
    assign link.odt       = odt_ff;
    assign link.cmd       = cmd_ff;
    assign link.dq_oe_ctl = 1'b0;
endmodule : opz_ctl

// *** hw/opz_dev.sv ***
// Device end: asynchronous ODT, power-down transition windows, ZQ calibration
`timescale 1ns/1ps
module opz_dev
    import opz_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic                  clk_en,
    opz_link_if.dev                    link,
    input  wire logic                  dll_frozen_pd,
    output logic                       rtt_on,
    output logic                       async_mode,
    output logic                       odt_window,
    output logic                       zq_busy,
    output logic                       zq_current_on,
    output logic                       drv_updated,
    output logic [OPZ_CNT_W-1:0]       cal_code
);
    import opz_pkg::*;

    typedef enum logic [1:0] {
        OPZ_ZQ_IDLE = 2'b00,
        OPZ_ZQ_CAL  = 2'b01,
        OPZ_ZQ_XFER = 2'b10
    } opz_zq_e;

    // ==============================================
    // Input synchronisers
    logic [OPZ_SYN_DEPTH-1:0] ck_sy_ff, cke_sy_ff, odt_sy_ff;
    logic [2:0]               cmd_s1_ff, cmd_s2_ff, cmd_s3_ff;
    logic                     ck_q_ff, cke_q_ff, odt_q_ff;

    // Three stages; a value counts once stages two and three agree
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ck_sy_ff  <= '0;
            cke_sy_ff <= '0;
            odt_sy_ff <= '0;
            cmd_s1_ff <= 3'h0;
            cmd_s2_ff <= 3'h0;
            cmd_s3_ff <= 3'h0;
        end else if (clk_en) begin
            ck_sy_ff  <= {ck_sy_ff[1:0], link.ck};
            cke_sy_ff <= {cke_sy_ff[1:0], link.cke};
            odt_sy_ff <= {odt_sy_ff[1:0], link.odt};
            cmd_s1_ff <= link.cmd;
            cmd_s2_ff <= cmd_s1_ff;
            cmd_s3_ff <= cmd_s2_ff;
        end
    end

    // Filtered levels
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ck_q_ff  <= 1'b0;
            cke_q_ff <= 1'b0;
            odt_q_ff <= 1'b0;
        end else if (clk_en) begin
            if (ck_sy_ff[1] == ck_sy_ff[2])   ck_q_ff  <= ck_sy_ff[2];
            if (cke_sy_ff[1] == cke_sy_ff[2]) cke_q_ff <= cke_sy_ff[2];
            if (odt_sy_ff[1] == odt_sy_ff[2]) odt_q_ff <= odt_sy_ff[2];
        end
    end

    // Link rising edge samples CKE, ODT and command
    logic     ck_prev_ff;
    wire      ck_rise = ck_q_ff & ~ck_prev_ff;
    wire      cmd_ok  = (cmd_s2_ff == cmd_s3_ff);
    opz_cmd_e cmd_now;
    assign cmd_now = cmd_ok ? opz_cmd_e'(cmd_s3_ff) : OPZ_CMD_NOP;

    // ==============================================
    // Power-down windows, counted in link cycles
    logic                 cke_reg_ff, pd_ff;
    logic [OPZ_CNT_W-1:0] ent_cnt_ff, exi_cnt_ff, ref_cnt_ff, pre_cnt_ff;
    wire  cke_fall = ck_rise & cke_reg_ff & ~cke_q_ff;
    wire  cke_risen = ck_rise & ~cke_reg_ff & cke_q_ff;
    wire  ref_busy = (ref_cnt_ff != '0);
    // Entry end: later of tCPDED and remaining tRFC
    wire [OPZ_CNT_W-1:0] ent_len = (ref_busy && ref_cnt_ff > OPZ_CNT_W'(OPZ_TCPDED)) ?
                                   ref_cnt_ff : OPZ_CNT_W'(OPZ_TCPDED);
    // A power-down no older than tANPD may still end in an exit whose window
    // reaches back over it, so short power-downs stay inside one window
    wire  exit_pre = pd_ff & (pre_cnt_ff <= OPZ_CNT_W'(OPZ_TANPD));

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ck_prev_ff <= 1'b0;
            cke_reg_ff <= 1'b0;  // Same level the controller drives in reset
            pd_ff      <= 1'b0;
            ent_cnt_ff <= '0;
            exi_cnt_ff <= '0;
            ref_cnt_ff <= '0;
            pre_cnt_ff <= '0;
        end else if (clk_en) begin
            ck_prev_ff <= ck_q_ff;
            if (ck_rise) begin
                cke_reg_ff <= cke_q_ff;
                if (cmd_now == OPZ_CMD_REF)
                    ref_cnt_ff <= OPZ_CNT_W'(OPZ_TRFC);
                else if (ref_busy)
                    ref_cnt_ff <= ref_cnt_ff - 1'b1;
                if (cke_fall && dll_frozen_pd) begin
                    pd_ff      <= 1'b1;
                    ent_cnt_ff <= ent_len;
                    pre_cnt_ff <= '0;
                end else if (ent_cnt_ff != '0)
                    ent_cnt_ff <= ent_cnt_ff - 1'b1;
                if (pd_ff && !cke_q_ff && pre_cnt_ff != '1)
                    pre_cnt_ff <= pre_cnt_ff + 1'b1;
                if (cke_risen && pd_ff) begin
                    pd_ff      <= 1'b0;
                    exi_cnt_ff <= OPZ_CNT_W'(OPZ_TXPDLL);
                end else if (exi_cnt_ff != '0)
                    exi_cnt_ff <= exi_cnt_ff - 1'b1;
            end
        end
    end

    // Window as far as the device can know it; the part of the entry window
    // before CKE was registered low has already passed unseen
    wire  in_window = (ent_cnt_ff != '0) | (exi_cnt_ff != '0) | exit_pre
                      | (cke_fall & dll_frozen_pd);
    assign odt_window = in_window;
    assign async_mode = pd_ff & dll_frozen_pd & ~in_window;

    // ==============================================
    // Termination: synchronous ODTLon/ODTLoff or asynchronous delay
    logic [OPZ_ODTLON:0]  odt_pipe_ff;
    logic [3:0]           adly_ff;
    wire  sync_target  = odt_pipe_ff[OPZ_ODTLON];
    // Asynchronous path takes the pin directly, with no AL added
    wire  async_target = adly_ff[OPZ_TAONPD_CYC];
    // Inside a window either response is legal; taking the earlier turn-on and
    // the later turn-off of the two keeps the change within the combined min/max bounds
    wire  rtt_next = zq_busy ? 1'b0 :
                     async_mode ? async_target :
                     in_window ? (sync_target | async_target) & (sync_target | odt_q_ff)
                               : sync_target;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            odt_pipe_ff <= '0;
            adly_ff     <= '0;
            rtt_on      <= 1'b0;
        end else if (clk_en) begin
            adly_ff <= {adly_ff[2:0], odt_q_ff};
            if (ck_rise) begin
                odt_pipe_ff <= {odt_pipe_ff[OPZ_ODTLON-1:0], odt_q_ff};
            end
            rtt_on <= rtt_next;
        end
    end

    // ==============================================
    // ZQ calibration engine
    opz_zq_e              zq_st_ff, nxt_zq_st;
    logic                 zq_first_ff, zq_long_ff;
    logic [OPZ_CNT_W-1:0] zq_cnt_ff;
    wire  zq_long_cmd  = ck_rise & (cmd_now == OPZ_CMD_ZQCL);
    wire  zq_short_cmd = ck_rise & (cmd_now == OPZ_CMD_ZQCS);
    // Long command after reset gets tZQinit, later ones tZQoper
    wire [OPZ_CNT_W-1:0] zq_len = zq_long_cmd ?
        (zq_first_ff ? OPZ_CNT_W'(OPZ_TZQINIT) : OPZ_CNT_W'(OPZ_TZQOPER))
        : OPZ_CNT_W'(OPZ_TZQCS);

    always_comb begin
        nxt_zq_st = zq_st_ff;
        unique case (zq_st_ff)
            OPZ_ZQ_IDLE: if (zq_long_cmd || zq_short_cmd) nxt_zq_st = OPZ_ZQ_CAL;
            OPZ_ZQ_CAL:  if (ck_rise && zq_cnt_ff == 10'h1) nxt_zq_st = OPZ_ZQ_XFER;
            OPZ_ZQ_XFER: nxt_zq_st = OPZ_ZQ_IDLE;
            default:     nxt_zq_st = OPZ_ZQ_IDLE;
        endcase
    end

    // Engine counts, then transfers its code into the drivers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            zq_st_ff    <= OPZ_ZQ_IDLE;
            zq_first_ff <= 1'b1;
            zq_long_ff  <= 1'b0;
            zq_cnt_ff   <= '0;
            cal_code    <= '0;
            drv_updated <= 1'b0;
        end else if (clk_en) begin
            zq_st_ff    <= nxt_zq_st;
            drv_updated <= 1'b0;
            if (zq_st_ff == OPZ_ZQ_IDLE && (zq_long_cmd || zq_short_cmd)) begin
                zq_cnt_ff  <= zq_len;
                zq_long_ff <= zq_long_cmd;
                if (zq_long_cmd) zq_first_ff <= 1'b0;
            end else if (zq_st_ff == OPZ_ZQ_CAL && ck_rise)
                zq_cnt_ff <= zq_cnt_ff - 1'b1;
            if (zq_st_ff == OPZ_ZQ_XFER) begin
                cal_code    <= cal_code + (zq_long_ff ? 10'h2 : 10'h1);
                drv_updated <= 1'b1;
            end
        end
    end

    assign zq_busy       = (zq_st_ff != OPZ_ZQ_IDLE);
    assign zq_current_on = (zq_st_ff == OPZ_ZQ_CAL);
    assign link.dq_oe_dev = 1'b0;
endmodule : opz_dev

// *** hw/opz_link_if.sv ***
// Interface: link between controller and memory device
`timescale 1ns/1ps
interface opz_link_if;
    logic                      ck;
    logic                      cke;
    logic                      odt;
    logic [2:0]                cmd;
    logic                      dq_oe_dev;
    logic                      dq_oe_ctl;

    modport ctl (output ck, output cke, output odt, output cmd, output dq_oe_ctl);
    modport dev (input ck, input cke, input odt, input cmd, output dq_oe_dev);
endinterface : opz_link_if

// *** hw/opz_pkg.sv ***
// Package: shared constants and types for the ODT power-down and ZQ calibration ends
package opz_pkg;
    // Command encodings on the command bus
    typedef enum logic [2:0] {
        OPZ_CMD_NOP   = 3'h0,
        OPZ_CMD_REF   = 3'h1,
        OPZ_CMD_ZQCL  = 3'h2,
        OPZ_CMD_ZQCS  = 3'h3,
        OPZ_CMD_SRX   = 3'h4,
        OPZ_CMD_OTHER = 3'h5
    } opz_cmd_e;

    // Link clock cycle time in ns, latencies in link cycles
    localparam int unsigned OPZ_TCK_NS      = 160;
    localparam int unsigned OPZ_WL          = 5;
    localparam int unsigned OPZ_TANPD       = OPZ_WL - 1;
    localparam int unsigned OPZ_ODTLON      = OPZ_WL - 2;
    localparam int unsigned OPZ_ODTLOFF     = OPZ_WL - 2;
    localparam int unsigned OPZ_TCPDED      = 1;
    localparam int unsigned OPZ_TRFC        = 44;
    localparam int unsigned OPZ_TXPDLL      = 10;
    localparam int unsigned OPZ_TXS         = 48;
    localparam int unsigned OPZ_TRP         = 4;
    localparam int unsigned OPZ_TZQINIT     = 512;
    localparam int unsigned OPZ_TZQOPER     = 256;
    localparam int unsigned OPZ_TZQCS       = 64;
    // Asynchronous delays in ns, converted to ref_clk cycles (5 ns)
    localparam int unsigned OPZ_REF_NS      = 5;
    localparam int unsigned OPZ_TAONPD_NS   = 2;
    localparam int unsigned OPZ_TAONPD_CYC  =
        (OPZ_TAONPD_NS + OPZ_REF_NS - 1) / OPZ_REF_NS;
    localparam int unsigned OPZ_TAOFPD_NS   = 2;
    localparam int unsigned OPZ_TAOFPD_CYC  =
        (OPZ_TAOFPD_NS + OPZ_REF_NS - 1) / OPZ_REF_NS;
    localparam int unsigned OPZ_CNT_W       = 10;
    localparam int unsigned OPZ_SYN_DEPTH   = 3;
endpackage : opz_pkg

// *** verification/odt_powerdown_and_zq_calibration_test.sv ***
// Testbench: controller and device ends joined over the link
`timescale 1ns/1ps
module odt_powerdown_and_zq_calibration_test;
    import opz_pkg::*;
    typedef struct {int lo; int hi;} opz_span_s;
    localparam int TOL = 2;
    logic ref_clk, rst_n, req_valid, req_cke, req_odt, banks_precharged, peer_zq_busy;
    logic [2:0] req_cmd;
    logic req_ready, zq_active, rtt_uncertain, rtt_on, async_mode, odt_window;
    logic zq_busy, zq_current_on, drv_updated, ck_d, zq_d, w_d, rtt_d, mon_win, cur, frozen;
    logic [OPZ_CNT_W-1:0] cal_code, code0;
    logic [31:0] seed = 32'h1e22;
    int n_fail, comparisons, link_n, zq_t0, w_t0, cur_wait;
    opz_span_s q_span[$];
    logic q_rtt[$];
    opz_link_if opz_link_if_i ();
    opz_dev opz_dev_i (.ref_clk, .rst_n, .clk_en(1'b1), .link(opz_link_if_i),
        .dll_frozen_pd(frozen), .rtt_on, .async_mode, .odt_window, .zq_busy,
        .zq_current_on, .drv_updated, .cal_code);
    opz_ctl opz_ctl_i (.ref_clk, .rst_n, .clk_en(1'b1), .link(opz_link_if_i), .req_valid,
        .req_cmd, .req_cke, .req_odt, .banks_precharged, .peer_zq_busy, .req_ready,
        .zq_active, .rtt_uncertain);
    opz_link_props opz_link_props_i (.ref_clk, .rst_n, .ck(opz_link_if_i.ck),
        .cke(opz_link_if_i.cke), .odt(opz_link_if_i.odt), .cmd(opz_link_if_i.cmd),
        .dq_oe_dev(opz_link_if_i.dq_oe_dev), .dq_oe_ctl(opz_link_if_i.dq_oe_ctl));
    // ==========================================
    // Clock, random source and comparisons
    initial begin
        ref_clk = 0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task results();
        if (n_fail == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    task check_val(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val
    task check_span(input int got);
        opz_span_s e;
        if (q_span.size()) e = q_span.pop_front();
        else e = '{-1, -1};
        comparisons++;
        if (got < e.lo || got > e.hi) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, e.lo);
        end
    endtask : check_span
    // Request on the user side, held until the ready pulse is sampled or lim cycles pass
    task req(input logic [2:0] c, input logic k, input logic o, input logic take, input int lim);
        logic got;
        got = 0;
        @(negedge ref_clk);
        req_valid = 1;
        req_cmd = c;
        req_cke = k;
        req_odt = o;
        for (int i = 0; i < lim && !got; i++) begin
            got = (req_ready === 1'b1);
            @(negedge ref_clk);
        end
        req_valid = 0;
        check_val(got, take);
    endtask : req
    task wait_win();
        repeat (100) @(negedge ref_clk);
        for (int i = 0; i < 3000 && odt_window !== 1'b0; i++) @(negedge ref_clk);
        check_val(odt_window, 1'b0);
    endtask : wait_win
    // Monitor: takes the oldest note whenever a result shows
    always @(negedge ref_clk) begin
        if (opz_link_if_i.ck && !ck_d) link_n++;
        ck_d = opz_link_if_i.ck;
        if (zq_busy === 1'b1 && !zq_d) begin
            zq_t0 = link_n;
            code0 = cal_code;
        end
        zq_d = (zq_busy === 1'b1);
        if (drv_updated === 1'b1) begin
            check_span(link_n - zq_t0);
            cur_wait = 4;
        end else if (cur_wait > 0) begin
            cur_wait--;
            if (cur_wait == 0) begin
                check_val(zq_current_on, 1'b0);
                check_val(cal_code !== code0, 1'b1);
            end
        end
        if (mon_win && odt_window === 1'b1 && !w_d) w_t0 = link_n;
        if (mon_win && odt_window === 1'b0 && w_d) check_span(link_n - w_t0);
        w_d = mon_win && (odt_window === 1'b1);
        if (rst_n && rtt_on !== rtt_d) begin
            check_val(rtt_on, q_rtt.size() ? q_rtt.pop_front() : ~rtt_on);
            rtt_d = rtt_on;
        end
    end
    initial begin
        repeat (90000) @(posedge ref_clk);
        n_fail++;
        results();
    end
    // Main sequence
    initial begin
        {ck_d, zq_d, w_d, rtt_d, mon_win} = '0;
        {rst_n, req_valid, req_odt, banks_precharged, peer_zq_busy} = '0;
        req_cke = 1;
        frozen = 1;
        req_cmd = OPZ_CMD_NOP;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk) rst_n = 1;
        req(OPZ_CMD_NOP, 1, 0, 1, 200);
        wait_win();
        mon_win = 1;
        req(OPZ_CMD_ZQCL, 1, 0, 0, 400);
        banks_precharged = 1;
        peer_zq_busy = 1;
        req(OPZ_CMD_ZQCL, 1, 0, 0, 400);
        peer_zq_busy = 0;
        q_span.push_back('{OPZ_TZQINIT - TOL, OPZ_TZQINIT + TOL});
        req(OPZ_CMD_ZQCL, 1, 0, 1, 100);
        repeat (64) @(negedge ref_clk);
        check_val(zq_active, 1'b1);
        check_val(zq_current_on, 1'b1);
        q_span.push_back('{OPZ_TZQOPER - TOL, OPZ_TZQOPER + TOL});
        req(OPZ_CMD_ZQCL, 1, 0, 1, 20000);
        q_span.push_back('{OPZ_TZQCS - TOL, OPZ_TZQCS + TOL});
        req(OPZ_CMD_ZQCS, 1, 0, 1, 20000);
        req(OPZ_CMD_SRX, 1, 0, 1, 4000);
        check_val(zq_active, 1'b0);
        q_span.push_back('{OPZ_TZQCS - TOL, OPZ_TZQCS + TOL});
        req(OPZ_CMD_ZQCS, 1, 0, 1, 4000);
        req(OPZ_CMD_NOP, 1, 0, 1, 4000);
        check_val(rtt_uncertain, 1'b0);
        q_span.push_back('{OPZ_TANPD + OPZ_TCPDED - TOL, OPZ_TANPD + OPZ_TCPDED + TOL});
        req(OPZ_CMD_NOP, 0, 0, 1, 400);
        wait_win();
        check_val(async_mode, 1'b1);
        cur = 0;
        for (int i = 0; i < 7; i++) begin
            req_odt = (i == 6) ? 1'b0 : rnd() & 32'h1;
            if (req_odt !== cur) q_rtt.push_back(req_odt);
            cur = req_odt;
            req(OPZ_CMD_NOP, 0, cur, 1, 400);
            repeat (40) @(negedge ref_clk);
            check_val(q_rtt.size() == 0, 1'b1);
        end
        q_span.push_back('{OPZ_TXPDLL - TOL, OPZ_TXPDLL + OPZ_TANPD + TOL});
        req(OPZ_CMD_NOP, 1, 0, 1, 400);
        wait_win();
        check_val(async_mode, 1'b0);
        req(OPZ_CMD_REF, 1, 0, 1, 400);
        // Power-down follows the refresh after tRP plus one link cycle
        q_span.push_back('{OPZ_TRFC - OPZ_TRP - 1 - TOL, OPZ_TRFC - OPZ_TRP + TOL});
        req(OPZ_CMD_NOP, 0, 0, 1, 400);
        repeat (320) @(negedge ref_clk);
        check_val(rtt_uncertain, 1'b1);
        wait_win();
        q_span.push_back('{OPZ_TXPDLL - TOL, OPZ_TXPDLL + OPZ_TANPD + TOL});
        req(OPZ_CMD_NOP, 1, 0, 1, 400);
        wait_win();
        q_span.push_back('{OPZ_TXPDLL - TOL, OPZ_TXPDLL + OPZ_TANPD + OPZ_TCPDED + TOL});
        req(OPZ_CMD_NOP, 0, 0, 1, 400);
        req(OPZ_CMD_NOP, 1, 0, 1, 400);
        wait_win();
        // Without the frozen-DLL strap a power-down opens no window
        frozen = 0;
        req(OPZ_CMD_NOP, 0, 0, 1, 400);
        repeat (100) @(negedge ref_clk);
        check_val(odt_window, 1'b0);
        check_val(async_mode, 1'b0);
        check_val(q_span.size() == 0 && q_rtt.size() == 0, 1'b1);
        results();
    end
endmodule : odt_powerdown_and_zq_calibration_test

// *** verification/opz_link_props.sv ***
// Checker: link assertions between the controller and device ends
`timescale 1ns/1ps
module opz_link_props
    import opz_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       ck,
    input wire logic       cke,
    input wire logic       odt,
    input wire logic [2:0] cmd,
    input wire logic       dq_oe_dev,
    input wire logic       dq_oe_ctl
);
    // ==========================================
    // Link cycle tracking of calibration and exit
    logic        ck_ff;
    logic        zq_seen_ff;
    logic [10:0] quiet_ff;
    logic [10:0] xs_ff;
    wire         ck_rise = ck & ~ck_ff;
    wire         is_zq   = (cmd == OPZ_CMD_ZQCL) || (cmd == OPZ_CMD_ZQCS);
    wire  [10:0] zq_len  = (cmd == OPZ_CMD_ZQCS) ? 11'(OPZ_TZQCS) :
                           zq_seen_ff ? 11'(OPZ_TZQOPER) : 11'(OPZ_TZQINIT);
    wire  [10:0] nxt_quiet = is_zq ? zq_len : (quiet_ff != 0 ? quiet_ff - 11'h1 : 11'h0);
    wire  [10:0] nxt_xs = (cmd == OPZ_CMD_SRX) ? 11'(OPZ_TXS) :
                          (xs_ff != 0 ? xs_ff - 11'h1 : 11'h0);
    // Counters step once per link clock rise
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ck_ff      <= 1'b0;
            zq_seen_ff <= 1'b0;
            quiet_ff   <= 11'h0;
            xs_ff      <= 11'h0;
        end else begin
            ck_ff <= ck;
            if (ck_rise) begin
                quiet_ff   <= nxt_quiet;
                xs_ff      <= nxt_xs;
                zq_seen_ff <= zq_seen_ff | (cmd == OPZ_CMD_ZQCL);
            end
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_link_clk_hold: assert property ($changed(ck) |=> $stable(ck) [*8])
        else $error("link clock half period too short");
    a_cmd_held: assert property ($changed(cmd) && cmd != OPZ_CMD_NOP |=> $stable(cmd) [*8])
        else $error("command not held");
    a_chan_quiet: assert property (ck_rise && quiet_ff > 11'h1 |-> cmd == OPZ_CMD_NOP)
        else $error("command during calibration");
    a_zq_after_srx: assert property (ck_rise && xs_ff > 11'h1 |-> !is_zq)
        else $error("calibration too soon after exit");
    a_cke_during_cal: assert property (quiet_ff > 11'h1 |-> cke)
        else $error("cke low during calibration");
    a_odt_off_cal: assert property (quiet_ff > 11'h1 |-> !odt)
        else $error("odt high during calibration");
    a_dq_hiz_cal: assert property (quiet_ff > 11'h1 |-> !dq_oe_dev && !dq_oe_ctl)
        else $error("data bus driven during calibration");
    a_zq_cmd_state: assert property (ck_rise && is_zq |-> cke && !odt)
        else $error("calibration issued with cke low or odt high");
endmodule : opz_link_props
